// >>> core/qbia_bid_former.v
// Forms the eighteen source bids from hardwired, programmed and live fields.
`timescale 1ns/1ps
`default_nettype none
`include "qbia_defines.vh"
module qbia_bid_former (
	input  wire [11:0]  rx_count,  // Receive byte count, 3 bits per channel.
	input  wire [3:0]   rx_error,  // Receiver error flags.
	input  wire [3:0]   rx_empty,  // Receive FIFO empty flags.
	input  wire [7:0]   tx_count,  // Transmit count, 2 bits per channel.
	input  wire [3:0]   tx_full,   // Transmit FIFO full flags.
	input  wire [3:0]   brk_act,   // Break detected per channel.
	input  wire [3:0]   cos_act,   // Change of state per channel.
	input  wire [1:0]   ct_done,   // Timer has timed out.
	input  wire [11:0]  brk_prio,  // Programmed break bits.
	input  wire [11:0]  cos_prio,  // Programmed change bits.
	input  wire [3:0]   ct_prio,   // Programmed timer bits.
	input  wire [17:0]  mask,      // Per-source bid enable.
	output wire [143:0] bids       // Eighteen 8-bit bids.
);
	genvar i;

	// ----------------------------------------
	// Per-channel sources
	// ----------------------------------------
	// Channel number in bits 1:0 keeps every bid unique and makes D win ties.
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			localparam integer CHI = i;
			localparam [1:0]   CH  = CHI[1:0];
			wire       rx_on  = mask[i] & ~rx_empty[i];
			wire       tx_on  = mask[4 + i] & ~tx_full[i];
			wire       brk_on = mask[8 + i] & brk_act[i];
			wire       cos_on = mask[12 + i] & cos_act[i];
			wire [2:0] rx_id  = rx_error[i] ? `QBIA_ID_RX_ERR : `QBIA_ID_RX_OK;
			assign bids[8*i +: 8] = rx_on ?
				{rx_count[3*i +: 3], rx_id, CH} : 8'h00;
			assign bids[8*(4+i) +: 8] = tx_on ?
				{2'h0, tx_count[2*i +: 2], `QBIA_ID_TX_LOW, CH} : 8'h00;
			assign bids[8*(8+i) +: 8] = brk_on ?
				{brk_prio[3*i +: 3], `QBIA_ID_BREAK, CH} : 8'h00;
			assign bids[8*(12+i) +: 8] = cos_on ?
				{cos_prio[3*i +: 3], `QBIA_ID_CHANGE, CH} : 8'h00;
		end
	endgenerate

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	// A timer that has not expired stays silent whatever its priority holds.
	assign bids[135:128] = (mask[16] & ct_done[0]) ?
		{ct_prio[1:0], `QBIA_ID_TIMER, 2'h0} : 8'h00;
	assign bids[143:136] = (mask[17] & ct_done[1]) ?
		{ct_prio[3:2], `QBIA_ID_TIMER, 2'h2} : 8'h00;
endmodule // qbia_bid_former
`default_nettype wire

// >>> core/qbia_defines.vh
// Constants for the bidding interrupt arbiter of the four-channel serial device.
`ifndef QBIA_DEFINES_VH
`define QBIA_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define QBIA_OFF_CTRL_WORD   6'h20
`define QBIA_OFF_VECTOR      6'h21
`define QBIA_OFF_CAPTURE     6'h22
`define QBIA_OFF_GLB_COUNT   6'h23
`define QBIA_OFF_GLB_CHAN    6'h24
`define QBIA_OFF_GLB_RX      6'h25
`define QBIA_OFF_GLB_TX      6'h26
`define QBIA_OFF_MASK_DATA   6'h28
`define QBIA_OFF_MASK_EVENT  6'h29
`define QBIA_OFF_CAPTURE_CMD 6'h2A
`define QBIA_OFF_MASK_TIMER  6'h2B
`define QBIA_OFF_PRIO_BASE   6'h30
`define QBIA_OFF_PRIO_TIMER  6'h34

// ----------------------------------------
// Reset values
// ----------------------------------------
`define QBIA_RST_CTRL_WORD   8'hFC
`define QBIA_RST_VECTOR      8'h0F
`define QBIA_RST_MASK        8'h00
`define QBIA_RST_PRIO        8'h00

// ----------------------------------------
// Bid layout and identity codes
// ----------------------------------------
`define QBIA_NSRC            18
`define QBIA_ID_RX_ERR       3'h7
`define QBIA_ID_RX_OK        3'h3
`define QBIA_ID_TX_LOW       2'h2
`define QBIA_ID_BREAK        3'h4
`define QBIA_ID_CHANGE       3'h1
`define QBIA_ID_TIMER        4'h5
`define QBIA_VEC_FULL        2'h0
`define QBIA_VEC_CHAN        2'h1
`define QBIA_VEC_TYPE        2'h2
`define QBIA_VEC_IDLE        8'hFF

`endif

// >>> core/qbia_interrupt_arbiter.v
// Top of the bidding interrupt arbiter with its registers and global access.
`timescale 1ns/1ps
`default_nettype none
`include "qbia_defines.vh"
module qbia_interrupt_arbiter (
	input  wire        clock,                      // 200 MHz system clock.
	input  wire        sys_rst,                    // Synchronous reset, high.
	input  wire [5:0]  reg_addr,                   // Register address.
	input  wire [7:0]  reg_wdata,                  // Register write data.
	input  wire        reg_wr,                     // Write strobe.
	input  wire        reg_rd,                     // Read strobe.
	output reg  [7:0]  reg_rdata,                  // Read data, next cycle.
	input  wire        interrupt_ack_strobe_n,     // Acknowledge pin, low.
	output wire        interrupt_request_line_n_o, // Open-drain level, zero.
	output wire        interrupt_request_line_n_oe,// Drive enable, high.
	output reg  [7:0]  vector_data,                // Vector for acknowledge.
	output reg         vector_valid,               // Vector stands, level.
	input  wire [11:0] rx_count,                   // Rx byte counts.
	input  wire [3:0]  rx_error,                   // Rx error flags.
	input  wire [3:0]  rx_empty,                   // Rx FIFO empty.
	input  wire [31:0] rx_data,                    // Rx head bytes.
	output reg  [3:0]  rx_pop,                     // Rx pop pulses.
	input  wire [7:0]  tx_count,                   // Tx counts.
	input  wire [3:0]  tx_full,                    // Tx FIFO full.
	output reg  [3:0]  tx_push,                    // Tx push pulses.
	output reg  [7:0]  tx_wdata,                   // Tx push byte.
	input  wire [3:0]  brk_act,                    // Break flags.
	input  wire [3:0]  cos_act,                    // Change flags.
	input  wire [1:0]  ct_done                     // Timer expired flags.
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [7:0]   interrupt_control_word;
	reg  [7:0]   vector_base;
	reg  [7:0]   current_interrupt_capture;
	reg  [17:0]  source_bid_mask;
	reg  [11:0]  brk_prio;
	reg  [11:0]  cos_prio;
	reg  [3:0]   ct_prio;
	reg          irq_active;
	reg          ack_prev;
	reg  [7:0]   winner;
	reg  [7:0]   next_rdata;
	reg  [7:0]   next_vector;
	wire [143:0] bids;
	wire         ack_sync;
	wire         ack_fall;
	wire         cmd_capture;
	wire         capture;
	wire [5:0]   threshold;
	wire [1:0]   cap_chan;
	wire [1:0]   win_chan;
	integer      k;

	// Page of the four per-channel priority registers, cut to the address field width.
	localparam [5:0] PRIO_BASE = `QBIA_OFF_PRIO_BASE;
	localparam [3:0] PRIO_PAGE = PRIO_BASE[5:2];

	// Larger of two bids; numeric order is the contiguous-ones order.
	function [7:0] qbia_max;
		input [7:0] a;
		input [7:0] b;
		begin
			qbia_max = (a > b) ? a : b;
		end
	endfunction

	// Byte lane of a four-channel bus.
	function [7:0] qbia_lane;
		input [31:0] bus;
		input [1:0]  ch;
		begin
			qbia_lane = bus[8*ch +: 8];
		end
	endfunction

	// Decoded one-hot channel pulse.
	function [3:0] qbia_onehot;
		input [1:0] ch;
		begin
			qbia_onehot = 4'h1 << ch;
		end
	endfunction

	// ----------------------------------------
	// Acknowledge pin
	// ----------------------------------------
	// The pin comes from the host, so it is synchronised before use.
	qbia_sync2 u_ack_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin_in  (interrupt_ack_strobe_n),
		.pin_out (ack_sync)
	);

	// Edge memory reads only the second stage.
	always @(posedge clock) begin
		if (sys_rst) begin
			ack_prev <= 1'b1;
		end else begin
			ack_prev <= ack_sync;
		end
	end

	assign ack_fall = ack_prev & ~ack_sync;

	// ----------------------------------------
	// Bid formation
	// ----------------------------------------
	qbia_bid_former u_bids (
		.rx_count (rx_count),
		.rx_error (rx_error),
		.rx_empty (rx_empty),
		.tx_count (tx_count),
		.tx_full  (tx_full),
		.brk_act  (brk_act),
		.cos_act  (cos_act),
		.ct_done  (ct_done),
		.brk_prio (brk_prio),
		.cos_prio (cos_prio),
		.ct_prio  (ct_prio),
		.mask     (source_bid_mask),
		.bids     (bids)
	);

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	// Silent sources bid zero, which is the no-interrupt identity.
	always @* begin
		winner = 8'h00;
		for (k = 0; k < `QBIA_NSRC; k = k + 1) begin
			winner = qbia_max(winner, bids[8*k +: 8]);
		end
	end

	assign threshold = interrupt_control_word[7:2];
	assign win_chan  = winner[1:0];

	// Channel bits stay out of the threshold test.
	always @(posedge clock) begin
		if (sys_rst) begin
			irq_active <= 1'b0;
		end else begin
			irq_active <= (winner[7:2] > threshold);
		end
	end

	// Open drain: only ever pulls low, released otherwise.
	assign interrupt_request_line_n_o  = 1'b0;
	assign interrupt_request_line_n_oe = irq_active;

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	assign cmd_capture = reg_wr & (reg_addr == `QBIA_OFF_CAPTURE_CMD);
	assign capture     = ack_fall | cmd_capture;
	assign cap_chan    = current_interrupt_capture[1:0];

	// One register load of the whole winner keeps the fields together.
	always @(posedge clock) begin
		if (sys_rst) begin
			current_interrupt_capture <= 8'h00;
		end else if (capture) begin
			current_interrupt_capture <= winner;
		end
	end

	// ----------------------------------------
	// Vector modification
	// ----------------------------------------
	// Built from the fresh winner so the vector matches the new capture.
	always @* begin
		case (interrupt_control_word[1:0])
			`QBIA_VEC_FULL: next_vector = vector_base;
			`QBIA_VEC_CHAN: next_vector = {vector_base[7:2], win_chan};
			`QBIA_VEC_TYPE: next_vector = {vector_base[7:5], winner[4:2], win_chan};
			default:        next_vector = `QBIA_VEC_IDLE;
		endcase
	end

	// The vector stands from acknowledge until the pin is released.
	always @(posedge clock) begin
		if (sys_rst) begin
			vector_data  <= `QBIA_VEC_IDLE;
			vector_valid <= 1'b0;
		end else if (ack_fall) begin
			vector_data  <= next_vector;
			vector_valid <= 1'b1;
		end else if (ack_sync) begin
			vector_valid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Priority and mask registers steer bidding directly.
	always @(posedge clock) begin
		if (sys_rst) begin
			interrupt_control_word <= `QBIA_RST_CTRL_WORD;
			vector_base            <= `QBIA_RST_VECTOR;
			source_bid_mask        <= {2'h0, `QBIA_RST_MASK, `QBIA_RST_MASK};
			brk_prio               <= 12'h000;
			cos_prio               <= 12'h000;
			ct_prio                <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == `QBIA_OFF_CTRL_WORD) begin
				interrupt_control_word <= reg_wdata;
			end else if (reg_addr == `QBIA_OFF_VECTOR) begin
				vector_base <= reg_wdata;
			end else if (reg_addr == `QBIA_OFF_MASK_DATA) begin
				source_bid_mask[7:0] <= reg_wdata;
			end else if (reg_addr == `QBIA_OFF_MASK_EVENT) begin
				source_bid_mask[15:8] <= reg_wdata;
			end else if (reg_addr == `QBIA_OFF_MASK_TIMER) begin
				source_bid_mask[17:16] <= reg_wdata[1:0];
			end else if (reg_addr[5:2] == PRIO_PAGE) begin
				brk_prio[3*reg_addr[1:0] +: 3] <= reg_wdata[2:0];
				cos_prio[3*reg_addr[1:0] +: 3] <= reg_wdata[5:3];
			end else if (reg_addr == `QBIA_OFF_PRIO_TIMER) begin
				ct_prio <= reg_wdata[3:0];
			end
		end
	end

	// ----------------------------------------
	// Global transmit
	// ----------------------------------------
	// The byte goes to whichever transmitter the last capture named.
	always @(posedge clock) begin
		if (sys_rst) begin
			tx_push  <= 4'h0;
			tx_wdata <= 8'h00;
		end else if (reg_wr && reg_addr == `QBIA_OFF_GLB_TX) begin
			tx_push  <= qbia_onehot(cap_chan);
			tx_wdata <= reg_wdata;
		end else begin
			tx_push  <= 4'h0;
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Global count and channel have no storage; they are views of the capture.
	always @* begin
		if (reg_addr == `QBIA_OFF_CTRL_WORD) begin
			next_rdata = interrupt_control_word;
		end else if (reg_addr == `QBIA_OFF_VECTOR) begin
			next_rdata = vector_base;
		end else if (reg_addr == `QBIA_OFF_CAPTURE) begin
			next_rdata = current_interrupt_capture;
		end else if (reg_addr == `QBIA_OFF_GLB_COUNT) begin
			next_rdata = {5'h00, current_interrupt_capture[7:5]};
		end else if (reg_addr == `QBIA_OFF_GLB_CHAN) begin
			next_rdata = {6'h00, cap_chan};
		end else if (reg_addr == `QBIA_OFF_GLB_RX) begin
			next_rdata = qbia_lane(rx_data, cap_chan);
		end else if (reg_addr == `QBIA_OFF_MASK_DATA) begin
			next_rdata = source_bid_mask[7:0];
		end else if (reg_addr == `QBIA_OFF_MASK_EVENT) begin
			next_rdata = source_bid_mask[15:8];
		end else if (reg_addr == `QBIA_OFF_MASK_TIMER) begin
			next_rdata = {6'h00, source_bid_mask[17:16]};
		end else if (reg_addr[5:2] == PRIO_PAGE) begin
			next_rdata = {2'h0, cos_prio[3*reg_addr[1:0] +: 3],
				brk_prio[3*reg_addr[1:0] +: 3]};
		end else if (reg_addr == `QBIA_OFF_PRIO_TIMER) begin
			next_rdata = {4'h0, ct_prio};
		end else begin
			next_rdata = 8'h00;
		end
	end

	// Read data and the receive pop share one edge, so the byte and pop agree.
	always @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			rx_pop    <= 4'h0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
			rx_pop    <= (reg_addr == `QBIA_OFF_GLB_RX) ?
				qbia_onehot(cap_chan) : 4'h0;
		end else begin
			rx_pop    <= 4'h0;
		end
	end
endmodule // qbia_interrupt_arbiter
`default_nettype wire

// >>> core/qbia_sync2.v
// Two-stage synchroniser for one asynchronous pin level.
`timescale 1ns/1ps
`default_nettype none
module qbia_sync2 (
	input  wire clock,   // System clock.
	input  wire sys_rst, // Synchronous reset, active high.
	input  wire pin_in,  // Asynchronous level.
	output reg  pin_out  // Level in the clock domain.
);
	reg stage1;

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	// Resets to one so an idle active-low pin raises no false edge.
	always @(posedge clock) begin
		if (sys_rst) begin
			stage1  <= 1'b1;
			pin_out <= 1'b1;
		end else begin
			stage1  <= pin_in;
			pin_out <= stage1;
		end
	end
endmodule // qbia_sync2
`default_nettype wire

// >>> dv/qbia_arbiter_asserts.sv
// Port assertions for the bidding interrupt arbiter.
`timescale 1ns/1ps
`default_nettype none
module qbia_arbiter_checker (
	input wire logic       clock,                       // System clock.
	input wire logic       sys_rst,                     // Synchronous reset.
	input wire logic [5:0] reg_addr,                    // Register address.
	input wire logic [7:0] reg_wdata,                   // Write data.
	input wire logic       reg_wr,                      // Write strobe.
	input wire logic       reg_rd,                      // Read strobe.
	input wire logic [7:0] reg_rdata,                   // Read data.
	input wire logic       interrupt_ack_strobe_n,      // Acknowledge pin.
	input wire logic       interrupt_request_line_n_o,  // Open-drain value.
	input wire logic       interrupt_request_line_n_oe, // Request drive.
	input wire logic [7:0] vector_data,                 // Vector byte.
	input wire logic       vector_valid,                // Vector stands.
	input wire logic [3:0] rx_empty,                    // Rx empty flags.
	input wire logic [3:0] rx_pop,                      // Rx pops.
	input wire logic [3:0] tx_full,                     // Tx full flags.
	input wire logic [3:0] tx_push,                     // Tx pushes.
	input wire logic [7:0] tx_wdata,                    // Tx byte.
	input wire logic [3:0] brk_act,                     // Break flags.
	input wire logic [3:0] cos_act,                     // Change flags.
	input wire logic [1:0] ct_done                      // Timer flags.
);
	// ----------------------------------------
	// Checks on the system clock
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// No source can bid at all, whatever the masks and priorities hold.
	wire quiet = (rx_empty == 4'hF) && (tx_full == 4'hF) && (brk_act == 4'h0) && (cos_act == 4'h0) && (ct_done == 2'h0);

	// Reset must be checked while it is asserted, so it overrides the default.
	reset_state_a: assert property (disable iff (1'b0) sys_rst |=>
		vector_data == 8'hFF && !vector_valid && !interrupt_request_line_n_oe && rx_pop == 4'h0 && tx_push == 4'h0)
		else $error("outputs not idle during reset");
	no_bidder_a: assert property (quiet |=> !interrupt_request_line_n_oe)
		else $error("request driven with no bidding source");
	drain_zero_a: assert property (interrupt_request_line_n_o == 1'b0)
		else $error("open-drain value not low");
	glb_count_a: assert property (reg_rd && reg_addr == 6'h23 |=> reg_rdata[7:3] == 5'h00)
		else $error("global count not right-justified");
	glb_chan_a: assert property (reg_rd && reg_addr == 6'h24 |=> reg_rdata[7:2] == 6'h00)
		else $error("global channel not right-justified");
	unmapped_read_a: assert property (reg_rd && reg_addr == 6'h3F |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	pop_cause_a: assert property (rx_pop != 4'h0 |-> $onehot(rx_pop) && $past(reg_rd) && $past(reg_addr) == 6'h25)
		else $error("receive pop without global receive read");
	pop_on_read_a: assert property (reg_rd && reg_addr == 6'h25 |=> $onehot(rx_pop))
		else $error("global receive read gave no pop");
	push_on_write_a: assert property (reg_wr && reg_addr == 6'h26 |=> $onehot(tx_push) && tx_wdata == $past(reg_wdata))
		else $error("global transmit write not delivered");
	push_cause_a: assert property (tx_push != 4'h0 |-> $past(reg_wr) && $past(reg_addr) == 6'h26)
		else $error("transmit push without global transmit write");
	vector_ack_a: assert property ($rose(vector_valid) |-> $past(interrupt_ack_strobe_n, 2) == 1'b0)
		else $error("vector offered without acknowledge");
endmodule // qbia_arbiter_checker

bind qbia_interrupt_arbiter qbia_arbiter_checker u_chk (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.interrupt_ack_strobe_n(interrupt_ack_strobe_n), .interrupt_request_line_n_o(interrupt_request_line_n_o),
	.interrupt_request_line_n_oe(interrupt_request_line_n_oe), .vector_data(vector_data),
	.vector_valid(vector_valid), .rx_empty(rx_empty), .rx_pop(rx_pop), .tx_full(tx_full), .tx_push(tx_push),
	.tx_wdata(tx_wdata), .brk_act(brk_act), .cos_act(cos_act), .ct_done(ct_done));
`default_nettype wire

// >>> dv/qbia_host_model.sv
// Host side model: request line pull-up and acknowledge driver.
`timescale 1ns/1ps
`default_nettype none
module qbia_host_model #(
	parameter int ACK_LEN = 6 // Cycles the acknowledge stays low.
) (
	input  wire logic clock,      // System clock.
	input  wire logic ack_go,     // Start an acknowledge cycle.
	input  wire logic req_o,      // Open-drain value from the device.
	input  wire logic req_oe,     // Open-drain enable from the device.
	output var  logic ack_n,      // Acknowledge pin, active low.
	output wire logic req_line_n  // Resolved request line.
);
	int cnt = 0;

	// The line floats to the pull-up level whenever the device lets go.
	assign req_line_n = req_oe ? req_o : 1'b1;

	// A host only acknowledges an interrupt it can see requested.
	initial ack_n = 1'b1;
	always @(posedge clock) begin
		if (ack_go && cnt == 0 && !req_line_n) begin
			ack_n <= 1'b0;
			cnt <= ACK_LEN;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			ack_n <= 1'b1;
			cnt <= 0;
		end
	end
endmodule // qbia_host_model
`default_nettype wire

// >>> dv/qbia_interrupt_arbiter_tb.sv
// Self-checking bench for the bidding interrupt arbiter.
`timescale 1ns/1ps
`default_nettype none
module qbia_interrupt_arbiter_tb;
	logic        clock, sys_rst, reg_wr, reg_rd, ack_go;
	logic [5:0]  reg_addr;
	logic [7:0]  reg_wdata, tx_count;
	logic [11:0] rx_count;
	logic [3:0]  rx_error, rx_empty, tx_full, brk_act, cos_act;
	logic [31:0] rx_data;
	logic [1:0]  ct_done;
	wire logic [7:0] reg_rdata, vector_data, tx_wdata;
	wire logic [3:0] rx_pop, tx_push;
	wire logic       req_o, req_oe, vector_valid, ack_n, req_line_n;
	int err_count = 0;
	int checked = 0;
	logic [7:0] vec_exp [4] = '{8'h80, 8'h83, 8'h8F, 8'hFF};

	// ----------------------------------------
	// Device, host and clock
	// ----------------------------------------
	qbia_interrupt_arbiter dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .interrupt_ack_strobe_n(ack_n),
		.interrupt_request_line_n_o(req_o), .interrupt_request_line_n_oe(req_oe), .vector_data(vector_data),
		.vector_valid(vector_valid), .rx_count(rx_count), .rx_error(rx_error), .rx_empty(rx_empty),
		.rx_data(rx_data), .rx_pop(rx_pop), .tx_count(tx_count), .tx_full(tx_full), .tx_push(tx_push),
		.tx_wdata(tx_wdata), .brk_act(brk_act), .cos_act(cos_act), .ct_done(ct_done));
	qbia_host_model host (.clock(clock), .ack_go(ack_go), .req_o(req_o), .req_oe(req_oe), .ack_n(ack_n),
		.req_line_n(req_line_n));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// Read data appear in the cycle after the strobe and then hold, so it is taken there.
	task automatic rdc(input logic [5:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 cmp8(reg_rdata, e);
	endtask
	task automatic wait_vv(input logic lvl);
		for (int i = 0; i < 30; i++) begin
			@(posedge clock);
			#1;
			if (vector_valid === lvl) return;
		end
		err_count++;
		$display("MISMATCH time=%0t got=%h exp=%h", $time, vector_valid, lvl);
		results();
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset;
		rdc(6'h20, 8'hFC);
		rdc(6'h21, 8'h0F);
		rdc(6'h22, 8'h00);
		wr(6'h3F, 8'hAA);
		rdc(6'h3F, 8'h00);
		cmp8({7'h0, req_oe}, 8'h00);
		cmp8(vector_data, 8'hFF);
		$display("test reset done");
	endtask
	task automatic test_rx;
		wr(6'h28, 8'hFF);
		wr(6'h29, 8'hFF);
		wr(6'h2B, 8'h03);
		wr(6'h20, 8'h00);
		@(posedge clock);
		rx_count <= 12'hA28;
		rx_empty <= 4'h5;
		rx_error <= 4'h2;
		wr(6'h2A, 8'h00);
		rdc(6'h22, 8'hBD);
		rdc(6'h23, 8'h05);
		rdc(6'h24, 8'h01);
		@(posedge clock);
		rx_error <= 4'h0;
		rdc(6'h22, 8'hBD);
		wr(6'h2A, 8'h00);
		rdc(6'h22, 8'hAF);
		$display("test rx done");
	endtask
	task automatic test_global;
		@(posedge clock);
		rx_data <= 32'h44332211;
		reg_rd <= 1'b1;
		reg_addr <= 6'h25;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 cmp8(reg_rdata, 8'h44);
		cmp8({4'h0, rx_pop}, 8'h08);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= 6'h26;
		reg_wdata <= 8'h5A;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1 cmp8({4'h0, tx_push}, 8'h08);
		cmp8(tx_wdata, 8'h5A);
		$display("test global done");
	endtask
	task automatic test_sources;
		@(posedge clock);
		rx_empty <= 4'hF;
		wr(6'h34, 8'hFF);
		repeat (2) @(posedge clock);
		#1 cmp8({7'h0, req_oe}, 8'h00);
		@(posedge clock);
		ct_done <= 2'h1;
		wr(6'h2A, 8'h00);
		rdc(6'h22, 8'hD4);
		@(posedge clock);
		ct_done <= 2'h3;
		wr(6'h2A, 8'h00);
		rdc(6'h22, 8'hD6);
		cmp8({7'h0, req_oe}, 8'h01);
		wr(6'h2B, 8'h00);
		wr(6'h2A, 8'h00);
		rdc(6'h22, 8'h00);
		cmp8({7'h0, req_oe}, 8'h00);
		@(posedge clock);
		tx_full <= 4'hB;
		tx_count <= 8'h30;
		wr(6'h2A, 8'h00);
		rdc(6'h22, 8'h3A);
		@(posedge clock);
		brk_act <= 4'h1;
		wr(6'h30, 8'h05);
		wr(6'h2A, 8'h00);
		rdc(6'h22, 8'hB0);
		@(posedge clock);
		cos_act <= 4'h2;
		wr(6'h31, 8'h38);
		wr(6'h2A, 8'h00);
		rdc(6'h22, 8'hE5);
		@(posedge clock);
		tx_full <= 4'hF;
		brk_act <= 4'h0;
		cos_act <= 4'h0;
		$display("test sources done");
	endtask
	task automatic test_threshold;
		@(posedge clock);
		rx_count <= 12'h002;
		rx_empty <= 4'hE;
		wr(6'h20, 8'h4C);
		repeat (2) @(posedge clock);
		#1 cmp8({7'h0, req_oe}, 8'h00);
		wr(6'h20, 8'h48);
		repeat (2) @(posedge clock);
		#1 cmp8({7'h0, req_line_n}, 8'h00);
		$display("test threshold done");
	endtask
	task automatic test_ack;
		@(posedge clock);
		rx_count <= 12'h400;
		rx_empty <= 4'h7;
		wr(6'h21, 8'h80);
		for (int f = 0; f < 4; f++) begin
			wr(6'h20, 8'(f));
			@(posedge clock);
			ack_go <= 1'b1;
			@(posedge clock);
			ack_go <= 1'b0;
			wait_vv(1'b1);
			cmp8(vector_data, vec_exp[f]);
			rdc(6'h22, 8'h4F);
			wait_vv(1'b0);
		end
		$display("test ack done");
	endtask

	// Inputs start quiet: nothing may bid until a scenario says so.
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, ack_go, reg_addr, reg_wdata} = '0;
		{rx_count, rx_error, rx_data, tx_count, brk_act, cos_act, ct_done} = '0;
		rx_empty = 4'hF;
		tx_full = 4'hF;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		test_reset();
		test_rx();
		test_global();
		test_sources();
		test_threshold();
		test_ack();
		results();
	end
endmodule // qbia_interrupt_arbiter_tb
`default_nettype wire
